// >>> dv/aca_host_model.sv
// Host model: one register command per call on the command port.
// Assumes the design answers at the taking edge, readable by the next falling edge.
`include "aca_map.svh"
`timescale 1ns/10ps
`default_nettype none
module aca_host_model (
  input  wire logic       mclk_i,
  input  wire logic       resp_valid_i,
  input  wire logic [7:0] resp_data_i,
  input  wire logic       digital_reset_i,
  output logic            cmd_valid_o,
  output logic            cmd_write_o,
  output logic      [7:0] cmd_addr_o,
  output logic      [7:0] cmd_wdata_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_addr_o  = 8'h00;
    cmd_wdata_o = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic rv, output logic rst, output logic [7:0] q);
    @(negedge mclk_i);
    cmd_valid_o = 1'b1;
    cmd_write_o = wr;
    cmd_addr_o  = a;
    cmd_wdata_o = (a == `ACA_ADDR_DEV_CTL) ? (d & 8'hC0) :
                  (a == `ACA_ADDR_DEV_CFG) ? (d & 8'h3F) : d;
    @(negedge mclk_i);
    rv  = resp_valid_i;
    rst = digital_reset_i;
    q   = resp_data_i;
    cmd_valid_o = 1'b0;
    // Stale bus inverted so a late latch shows up
    cmd_write_o = ~wr;
    cmd_addr_o  = ~a;
    cmd_wdata_o = ~d;
  endtask : xfer
endmodule : aca_host_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the config array, driven through the host model.
// Assumes default key values 0, 1, 2 on the design.
`include "aca_map.svh"
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       mclk_i, reset_n_i, cv, cw, rv_o, rst_o, lock, fmt, ofm, cen, wce, oce, av, rv, rst;
  logic [7:0] ca, cd, rd_o, pn, ocrc, q, prev;
  logic [12:0] sn;
  logic       stx, sty;
  logic [9:0] araw, adat;
  logic [2:0] arm;
  int         err_total, num_checks, cyc, i;

  aca_host_model host (.mclk_i(mclk_i), .resp_valid_i(rv_o), .resp_data_i(rd_o),
    .digital_reset_i(rst_o), .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_addr_o(ca),
    .cmd_wdata_o(cd));
  aca_regs DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cv), .cmd_write_i(cw),
    .cmd_addr_i(ca), .cmd_wdata_i(cd), .resp_valid_o(rv_o), .resp_data_o(rd_o),
    .otp_serial_i(sn), .otp_selftest_magnitude_x_i(stx), .otp_selftest_magnitude_y_i(sty), .otp_part_number_i(pn),
    .otp_crc_i(ocrc), .accel_valid_i(av), .accel_raw_i(araw), .accel_data_o(adat),
    .digital_reset_o(rst_o), .init_done_lock_o(lock), .unsigned_format_select_o(fmt),
    .offset_monitor_enable_o(ofm), .arm_output_mode_o(arm),
    .writable_crc_check_en_o(cen), .writable_crc_error_o(wce), .otp_crc_error_o(oce));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Ceiling well above the roughly 80 cycles the tests need
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks = num_checks + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Reference CRC-8 over the OTP vector, MSB first
  function automatic logic [7:0] ref_crc(input logic [23:0] v);
    logic [7:0] c;
    logic       fb;
    c = `ACA_CRC_INIT;
    for (int k = 23; k >= 0; k--) begin
      fb = c[7] ^ v[k];
      c  = {c[6:0], 1'b0} ^ ({8{fb}} & `ACA_CRC_POLY);
    end
    return c;
  endfunction : ref_crc

  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic er);
    host.xfer(w, a, d, rv, rst, q);
    chk({6'h00, rst, rv, q}, {6'h00, er, 1'b1, e});
  endtask : cmd

  task automatic samp(input logic [9:0] r, input logic [9:0] e);
    @(negedge mclk_i);
    av   = 1'b1;
    araw = r;
    @(negedge mclk_i);
    av   = 1'b0;
    chk({6'h00, adat}, {6'h00, e});
  endtask : samp

  initial begin
    err_total = 0;
    num_checks = 0;
    cyc = 0;
    reset_n_i = 1'b0;
    sn = 13'h1ABC;
    stx = 1'b1;
    sty = 1'b0;
    pn = 8'h5A;
    ocrc = ref_crc({1'b0, stx, sty, sn, pn});
    av = 1'b0;
    araw = 10'h000;
    repeat (6) @(negedge mclk_i);
    reset_n_i = 1'b1;
    chk({lock, fmt, ofm, arm, cen, wce}, 16'h0000);
    cmd(1'b0, `ACA_ADDR_DEV_CFG, 8'h00, 8'h00, 1'b0);
    cmd(1'b0, `ACA_ADDR_DEV_CTL, 8'h00, 8'h00, 1'b0);
    $display("test reset done");
    cmd(1'b0, `ACA_ADDR_SN_LO, 8'h00, sn[7:0], 1'b0);
    cmd(1'b0, `ACA_ADDR_SN_HI, 8'h00, {3'h0, sn[12:8]}, 1'b0);
    cmd(1'b1, `ACA_ADDR_PART_NUM, 8'h11, pn, 1'b0);
    cmd(1'b0, `ACA_ADDR_PART_NUM, 8'h00, pn, 1'b0);
    cmd(1'b0, `ACA_ADDR_FCT_CFG_X, 8'h00, {7'h00, stx}, 1'b0);
    cmd(1'b0, `ACA_ADDR_FCT_CFG_Y, 8'h00, {7'h00, sty}, 1'b0);
    cmd(1'b1, 8'h3C, 8'hA5, 8'h00, 1'b0);
    cmd(1'b0, 8'h3C, 8'h00, 8'h00, 1'b0);
    chk({15'h0000, oce}, 16'h0000);
    ocrc = ~ocrc;
    @(negedge mclk_i);
    chk({15'h0000, oce}, 16'h0001);
    ocrc = ~ocrc;
    sn = sn ^ 13'h0001;
    @(negedge mclk_i);
    chk({15'h0000, oce}, 16'h0001);
    sn = sn ^ 13'h0001;
    @(negedge mclk_i);
    chk({15'h0000, oce}, 16'h0000);
    $display("test otp done");
    prev = 8'h00;
    for (i = 0; i < 8; i++) begin
      cmd(1'b1, `ACA_ADDR_DEV_CFG, {3'h0, i[0], i[1], i[2:0]}, prev, 1'b0);
      prev = {3'h0, i[0], i[1], i[2:0]};
      chk({fmt, ofm, arm}, {11'h000, i[0], i[1], i[2:0]});
    end
    samp(10'h000, `ACA_ZERO_G_UNSIGNED);
    samp(10'h3FF, 10'h1FF);
    cmd(1'b1, `ACA_ADDR_DEV_CFG, 8'h08, prev, 1'b0);
    samp(10'h3FF, 10'h3FF);
    cmd(1'b1, `ACA_ADDR_DEV_CTL, 8'hC0, 8'h00, 1'b0);
    $display("test config done");
    cmd(1'b1, `ACA_ADDR_DEV_CFG, 8'h35, 8'h08, 1'b0);
    chk({lock, cen, fmt, wce}, 16'h000E);
    cmd(1'b1, `ACA_ADDR_DEV_CFG, 8'h00, 8'h35, 1'b0);
    cmd(1'b0, `ACA_ADDR_DEV_CFG, 8'h00, 8'h35, 1'b0);
    chk({15'h0000, wce}, 16'h0000);
    cmd(1'b1, `ACA_ADDR_DEV_CTL, 8'h00, 8'h00, 1'b0);
    $display("test lock done");
    // Broken sequences: read in the middle, then wrong order
    cmd(1'b1, `ACA_ADDR_DEV_CTL, 8'h40, 8'h00, 1'b0);
    cmd(1'b0, `ACA_ADDR_DEV_CTL, 8'h00, 8'h00, 1'b0);
    cmd(1'b1, `ACA_ADDR_DEV_CTL, 8'h80, 8'h00, 1'b0);
    cmd(1'b1, `ACA_ADDR_DEV_CTL, 8'h00, 8'h00, 1'b0);
    cmd(1'b1, `ACA_ADDR_DEV_CTL, 8'h80, 8'h00, 1'b0);
    chk({15'h0000, lock}, 16'h0001);
    for (i = 0; i < 3; i++) begin
      cmd(1'b1, `ACA_ADDR_DEV_CTL, {i[1:0], 6'h00}, 8'h00, i == 2);
    end
    @(negedge mclk_i);
    chk({lock, fmt, ofm, arm, rst_o}, 16'h0000);
    cmd(1'b0, `ACA_ADDR_DEV_CFG, 8'h00, 8'h00, 1'b0);
    $display("test key reset done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire

// >>> hw/aca_crc8.sv
// Combinational CRC-8 over a parameterised data vector, MSB first.
// Assumes the caller registers the result where timing requires.
`include "aca_map.svh"
`timescale 1ns/10ps
`default_nettype none

module aca_crc8 #(
  parameter int DATA_W = 8
) (
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [7:0]        crc_o
);

  if (DATA_W < 1) begin : g_chk
    $error("aca_crc8: DATA_W must be at least 1");
  end

  function automatic logic [7:0] crc_calc(input logic [DATA_W-1:0] d);
    logic [7:0] c;
    c = `ACA_CRC_INIT;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ `ACA_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc_calc

  always_comb begin
    crc_o = crc_calc(data_i);
  end

endmodule : aca_crc8

`default_nettype wire

// >>> hw/aca_map.svh
// Address map, field positions, reset values and fixed figures of the config array.
// Assumes 8-bit register addresses and 8-bit register data.
`ifndef ACA_MAP_SVH
`define ACA_MAP_SVH

`define ACA_ADDR_W          8
`define ACA_DATA_W          8

`define ACA_ADDR_SN_LO      8'h00
`define ACA_ADDR_SN_HI      8'h01
`define ACA_ADDR_PART_NUM   8'h05
`define ACA_ADDR_FCT_CFG_X  8'h06
`define ACA_ADDR_FCT_CFG_Y  8'h07
`define ACA_ADDR_DEV_CTL    8'h10
`define ACA_ADDR_DEV_CFG    8'h11

`define ACA_CTL_KEY_HI_BIT  7
`define ACA_CTL_KEY_LO_BIT  6

`define ACA_CFG_LOCK_BIT    5
`define ACA_CFG_UFMT_BIT    4
`define ACA_CFG_OFFSET_MONITOR_ENABLE_BIT   3
`define ACA_CFG_ARM_MSB     2
`define ACA_CFG_ARM_LSB     0
`define ACA_CFG_WMASK       8'h3F
`define ACA_CFG_RESET       8'h00

`define ACA_STMAG_BIT       0
`define ACA_SERIAL_W        13

`define ACA_ACCEL_W         10
`define ACA_ZERO_G_UNSIGNED 10'h200

`define ACA_CRC_POLY        8'h2F
`define ACA_CRC_INIT        8'hFF

`endif

// >>> hw/aca_pkg.sv
// Types shared by the config array design.
// Assumes aca_map.svh supplies all numeric constants.
package aca_pkg;

  typedef enum logic [1:0] {
    ACA_SEQ_IDLE = 2'b00,
    ACA_SEQ_GOT1 = 2'b01,
    ACA_SEQ_GOT2 = 2'b10
  } aca_seq_t;

endpackage : aca_pkg

// >>> hw/aca_regs.sv
// Customer data array: OTP shadow view, control and configuration registers, key reset.
// Assumes a same-clock SPI front end that presents one decoded command per valid pulse.
//
// Summary of operation
// - Three consecutive key writes cause digital reset.
// - Keys must be back-to-back, ordered, else no reset.
// - Write response shows both key bits zero.
// - Reads return zero keys and abort sequence.
// - Control register writable before and after lock.
// - Configuration writable only before lock; CRC covered.
// - Lock blocks all writes except control register.
// - Lock stays set until device reset.
// - Writable CRC check runs only while locked.
// - Format bit one gives unsigned, zero at 512.
// - Format bit zero gives signed, zero at 0.
// - Offset monitor enable follows its bit.
// - Three-bit field selects arming pin mode.
// - Read-only 13-bit serial number from OTP.
// - Serial number included in OTP CRC.
// - OTP and writable blocks have independent CRCs.
// - Reserved registers read-only, no effect.
// - Factory bits report low/high self-test magnitude.
// - Part number register read-only, no effect.
`include "aca_map.svh"
`timescale 1ns/10ps
`default_nettype none

module aca_regs #(
  parameter logic [1:0] KEY_STEP1 = 2'h0,
  parameter logic [1:0] KEY_STEP2 = 2'h1,
  parameter logic [1:0] KEY_STEP3 = 2'h2
) (
  input  wire logic                      mclk_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      cmd_valid_i,
  input  wire logic                      cmd_write_i,
  input  wire logic [`ACA_ADDR_W-1:0]    cmd_addr_i,
  input  wire logic [`ACA_DATA_W-1:0]    cmd_wdata_i,
  output logic                           resp_valid_o,
  output logic      [`ACA_DATA_W-1:0]    resp_data_o,
  input  wire logic [`ACA_SERIAL_W-1:0]  otp_serial_i,
  input  wire logic                      otp_selftest_magnitude_x_i,
  input  wire logic                      otp_selftest_magnitude_y_i,
  input  wire logic [7:0]                otp_part_number_i,
  input  wire logic [7:0]                otp_crc_i,
  input  wire logic                      accel_valid_i,
  input  wire logic [`ACA_ACCEL_W-1:0]   accel_raw_i,
  output logic      [`ACA_ACCEL_W-1:0]   accel_data_o,
  output logic                           digital_reset_o,
  output logic                           init_done_lock_o,
  output logic                           unsigned_format_select_o,
  output logic                           offset_monitor_enable_o,
  output logic      [2:0]                arm_output_mode_o,
  output logic                           writable_crc_check_en_o,
  output logic                           writable_crc_error_o,
  output logic                           otp_crc_error_o
);

  if (KEY_STEP1 == KEY_STEP2 || KEY_STEP2 == KEY_STEP3) begin : g_chk
    $error("aca_regs: adjacent key values must differ");
  end

  // Internal reset: pin or completed key sequence
  logic rst;
  logic soft_rst;
  assign rst = !reset_n_i || soft_rst;

  // Command decode
  logic              ctl_wr;
  logic              cfg_wr;
  logic [1:0]        key;
  assign ctl_wr = cmd_valid_i && cmd_write_i && (cmd_addr_i == `ACA_ADDR_DEV_CTL);
  assign cfg_wr = cmd_valid_i && cmd_write_i && (cmd_addr_i == `ACA_ADDR_DEV_CFG);
  assign key    = cmd_wdata_i[`ACA_CTL_KEY_HI_BIT:`ACA_CTL_KEY_LO_BIT];

  // Key sequencer
  aca_pkg::aca_seq_t seq;
  aca_pkg::aca_seq_t next_seq;
  logic              next_soft_rst;

  always_comb begin
    next_seq      = seq;
    next_soft_rst = 1'b0;
    if (cmd_valid_i) begin
      // A first-key write restarts at step one, unless in step three it also matches KEY_STEP3
      next_seq = (ctl_wr && key == KEY_STEP1) ? aca_pkg::ACA_SEQ_GOT1 : aca_pkg::ACA_SEQ_IDLE;
      case (seq)
        aca_pkg::ACA_SEQ_IDLE: begin
        end
        aca_pkg::ACA_SEQ_GOT1: begin
          if (ctl_wr && key == KEY_STEP2) begin
            next_seq = aca_pkg::ACA_SEQ_GOT2;
          end
        end
        aca_pkg::ACA_SEQ_GOT2: begin
          if (ctl_wr && key == KEY_STEP3) begin
            next_seq      = aca_pkg::ACA_SEQ_IDLE;
            next_soft_rst = 1'b1;
          end
        end
        default: begin
          next_seq = aca_pkg::ACA_SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst) begin
      seq <= aca_pkg::ACA_SEQ_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  // Pulse clears itself on the next edge through its own !soft_rst term
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= next_soft_rst && !soft_rst;
    end
  end

  assign digital_reset_o = soft_rst;

  // Configuration register; control register holds no state of its own
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic       lock;
  assign lock = cfg[`ACA_CFG_LOCK_BIT];

  always_comb begin
    next_cfg = cfg;
    // Control writes never touch configuration, locked or not
    if (cfg_wr && !lock) begin
      next_cfg = cmd_wdata_i & `ACA_CFG_WMASK;
    end
    // Lock only ever sets here
    next_cfg[`ACA_CFG_LOCK_BIT] = next_cfg[`ACA_CFG_LOCK_BIT] || lock;
  end

  always_ff @(posedge mclk_i) begin
    if (rst) begin
      cfg <= `ACA_CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign init_done_lock_o         = lock;
  assign unsigned_format_select_o = cfg[`ACA_CFG_UFMT_BIT];
  assign offset_monitor_enable_o  = cfg[`ACA_CFG_OFFSET_MONITOR_ENABLE_BIT];
  assign arm_output_mode_o        = cfg[`ACA_CFG_ARM_MSB:`ACA_CFG_ARM_LSB];
  assign writable_crc_check_en_o  = lock;

  // Independent CRC circuits
  logic [7:0] wr_crc_now;
  logic [7:0] wr_crc_next;
  logic [7:0] otp_crc_now;

  aca_crc8 #(
    .DATA_W (8)
  ) u_wr_crc (
    .data_i (cfg),
    .crc_o  (wr_crc_now)
  );

  // Reference follows the value being stored, so the locking write itself matches
  aca_crc8 #(
    .DATA_W (8)
  ) u_wr_crc_next (
    .data_i (next_cfg),
    .crc_o  (wr_crc_next)
  );

  aca_crc8 #(
    .DATA_W (24)
  ) u_otp_crc (
    .data_i ({1'b0, otp_selftest_magnitude_x_i, otp_selftest_magnitude_y_i, otp_serial_i, otp_part_number_i[7:0]} >> 0),
    .crc_o  (otp_crc_now)
  );

  // Reference taken at the moment the lock sets; later upsets show as mismatch
  logic [7:0] wr_crc_ref;
  logic [7:0] next_wr_crc_ref;
  logic       next_wr_crc_err;
  logic       next_otp_crc_err;

  always_comb begin
    next_wr_crc_ref  = wr_crc_ref;
    next_wr_crc_err  = writable_crc_error_o;
    next_otp_crc_err = (otp_crc_now != otp_crc_i);
    if (!lock) begin
      next_wr_crc_ref = wr_crc_next;
    end else if (wr_crc_now != wr_crc_ref) begin
      next_wr_crc_err = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst) begin
      wr_crc_ref           <= 8'h00;
      writable_crc_error_o <= 1'b0;
      otp_crc_error_o      <= 1'b0;
    end else begin
      wr_crc_ref           <= next_wr_crc_ref;
      writable_crc_error_o <= next_wr_crc_err;
      otp_crc_error_o      <= next_otp_crc_err;
    end
  end

  // Read view; anything not listed reads zero and stores nothing
  function automatic logic [7:0] read_reg(input logic [`ACA_ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ACA_ADDR_SN_LO:     v = otp_serial_i[7:0];
      `ACA_ADDR_SN_HI:     v = {3'h0, otp_serial_i[12:8]};
      `ACA_ADDR_PART_NUM:  v = otp_part_number_i;
      `ACA_ADDR_FCT_CFG_X: v[`ACA_STMAG_BIT] = otp_selftest_magnitude_x_i;
      `ACA_ADDR_FCT_CFG_Y: v[`ACA_STMAG_BIT] = otp_selftest_magnitude_y_i;
      `ACA_ADDR_DEV_CTL:   v = 8'h00;
      `ACA_ADDR_DEV_CFG:   v = cfg;
      default:             v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  // Response and data formatting
  logic [7:0]              next_resp_data;
  logic [`ACA_ACCEL_W-1:0] next_accel;

  always_comb begin
    next_resp_data = cmd_valid_i ? read_reg(cmd_addr_i) : resp_data_o;
    next_accel     = accel_data_o;
    if (accel_valid_i) begin
      // Offset of 512 is an MSB flip in ten bits
      next_accel = unsigned_format_select_o
                   ? `ACA_ACCEL_W'(accel_raw_i + `ACA_ZERO_G_UNSIGNED)
                   : accel_raw_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst) begin
      resp_valid_o <= 1'b0;
      resp_data_o  <= 8'h00;
      accel_data_o <= '0;
    end else begin
      resp_valid_o <= cmd_valid_i;
      resp_data_o  <= next_resp_data;
      accel_data_o <= next_accel;
    end
  end

  // Checks
  a_key_reset_fires: assert property (@(posedge mclk_i) disable iff (rst)
    (seq == aca_pkg::ACA_SEQ_GOT2 && ctl_wr && key == KEY_STEP3) |=> digital_reset_o)
    else $error("third key write did not reset");

  a_seq_breaks: assert property (@(posedge mclk_i) disable iff (rst)
    (seq == aca_pkg::ACA_SEQ_GOT1 && cmd_valid_i && !(ctl_wr && key == KEY_STEP2))
    |=> seq != aca_pkg::ACA_SEQ_GOT2 ##1 !digital_reset_o)
    else $error("sequence advanced on wrong command");

  a_resp_key_zero: assert property (@(posedge mclk_i) disable iff (rst)
    (cmd_valid_i && cmd_addr_i == `ACA_ADDR_DEV_CTL) |=> resp_valid_o && resp_data_o[7:6] == 2'b00)
    else $error("key bits not zero in response");

  a_read_aborts: assert property (@(posedge mclk_i) disable iff (rst)
    (cmd_valid_i && !cmd_write_i) |=> seq == aca_pkg::ACA_SEQ_IDLE)
    else $error("read did not abort sequence");

  a_cfg_locked: assert property (@(posedge mclk_i) disable iff (rst)
    (lock && !soft_rst) |=> $stable(cfg))
    else $error("configuration changed while locked");

  a_cfg_write: assert property (@(posedge mclk_i) disable iff (rst)
    (cfg_wr && !lock) |=> arm_output_mode_o == $past(cmd_wdata_i[2:0])
                          && offset_monitor_enable_o == $past(cmd_wdata_i[3]))
    else $error("unlocked configuration write lost");

  a_lock_sticky: assert property (@(posedge mclk_i) disable iff (rst)
    init_done_lock_o |=> init_done_lock_o)
    else $error("lock cleared without reset");

  a_crc_gated: assert property (@(posedge mclk_i) disable iff (rst)
    writable_crc_error_o |-> writable_crc_check_en_o)
    else $error("writable crc error while unlocked");

  a_fmt_unsigned: assert property (@(posedge mclk_i) disable iff (rst)
    (accel_valid_i && unsigned_format_select_o)
    |=> accel_data_o == ($past(accel_raw_i) ^ `ACA_ZERO_G_UNSIGNED))
    else $error("unsigned format wrong");

  a_fmt_signed: assert property (@(posedge mclk_i) disable iff (rst)
    (accel_valid_i && !unsigned_format_select_o) |=> accel_data_o == $past(accel_raw_i))
    else $error("signed format wrong");

endmodule : aca_regs

`default_nettype wire
